// ==== rtl/adcs_pkg.sv ====
package adcs_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] ADR_CONFIG = 5'h00;
    localparam logic [4:0] ADR_SETUP  = 5'h04;
    localparam logic [4:0] ADR_CTRL   = 5'h08;
    localparam logic [4:0] ADR_STATUS = 5'h0c;
    localparam logic [4:0] ADR_RESULT = 5'h10;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_RST  = 8'h01;
    localparam logic [3:0] SETUP_RST   = 4'h0;
    localparam int         CFG_SGL     = 0;
    localparam int         CFG_CS_LO   = 1;
    localparam int         CFG_SCAN_LO = 5;
    localparam int         SET_SEL0    = 0;
    localparam int         SET_REF_PIN_SELECT_BIT    = 1;
    localparam int         SET_SEL2    = 2;
    localparam int         SET_EXTCLK  = 3;
    localparam int         CTL_START   = 0;
    localparam int         CTL_NACK    = 1;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_REFON  = 1;
    localparam int         STAT_SETTLE = 2;
    localparam int         STAT_RSVERR = 3;
    localparam int         STAT_FILL   = 8;
    localparam int         RES_VALID   = 12;

    // ------------------------------------------------------------
    // Scan modes and channel constants
    // ------------------------------------------------------------
    localparam logic [1:0] SCAN_SEQ   = 2'h0;
    localparam logic [1:0] SCAN_REP   = 2'h1;
    localparam logic [1:0] SCAN_UPPER = 2'h2;
    localparam logic [1:0] SCAN_ONE   = 2'h3;
    localparam logic [3:0] REPEAT_CNT = 4'h8;
    localparam logic [3:0] CH_FIRST   = 4'h0;
    localparam logic [3:0] CS_RSV_MIN = 4'hc;
    localparam logic [3:0] TOP_12     = 4'hb;
    localparam logic [3:0] TOP_4      = 4'h3;
    localparam logic [3:0] UP_START12 = 4'h6;
    localparam logic [3:0] UP_START4  = 4'h2;
    localparam int         RES_DEPTH_DEF = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 200;
    localparam int REF_SETTLE_US = 80;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } adcs_state_t;

endpackage : adcs_pkg

// ==== rtl/adcs_scan_seq.sv ====
`timescale 1ns/1ps
// Function
// - single-ended codes 0-11 pick input against ground
// - differential codes pick even/odd pair, odd reverses
// - four-channel part forces upper select bits zero
// - shared pin single-ended read returns ground when it is set as reference
// - top differential pair treats shared pin as ground when it is set as reference
// - select bit 0 fixes polarity of scanned pairs
// - mode 00 scans up from input 0
// - mode 01 internal clock converts eight times
// - four-channel mode 10 scans up from input 2
// - twelve-channel mode 10 scans up from input 6
// - mode 11 internal clock converts once
// - external clock in modes 01 and 11 repeats until master stops it
// - reference select makes shared pin input or reference
// - always-on reference stays on until reconfigured
// - shared pin used as reference is skipped in single-ended scans
// - scan mode field resets to 00
// - power-up config single-ended input 0, supply ref
module adcs_scan_seq import adcs_pkg::*; #(
    parameter bit TWELVE_CH         = 1'b1,
    parameter int RES_DEPTH         = RES_DEPTH_DEF,
    parameter int REF_SETTLE_CYCLES = REF_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Converter core
    output logic             convStart,
    output logic      [3:0]  muxPos,
    output logic      [3:0]  muxNeg,
    output logic             posGround,
    output logic             negGround,
    input  wire logic        convDone,
    input  wire logic [7:0]  convData,
    // Reference control
    output logic             refPowerOn,
    output logic             refPinDrive,
    output logic             refPinIn
);

    // ------------------------------------------------------------
    // Local constants and state
    // ------------------------------------------------------------
    localparam int PW = $clog2(RES_DEPTH);
    localparam int SW = $clog2(REF_SETTLE_CYCLES + 1);
    localparam logic [3:0] TOP      = TWELVE_CH ? TOP_12 : TOP_4;
    localparam logic [3:0] UP_START = TWELVE_CH ? UP_START12 : UP_START4;
    localparam logic [PW:0] FULL    = (PW + 1)'(RES_DEPTH);
    localparam logic [SW-1:0] SETTLE = SW'(REF_SETTLE_CYCLES);

    typedef struct packed {
        logic [7:0]                  cfg;
        logic [3:0]                  setup;
        logic [7:0]                  run;
        logic                        runExt;
        adcs_state_t                 state;
        logic [3:0]                  cur;
        logic [3:0]                  last;
        logic [3:0]                  reps;
        logic [4:0]                  cnt;
        logic                        stopReq;
        logic                        rsvErr;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [PW:0]                 fill;
        logic [RES_DEPTH-1:0][11:0]  mem;
        logic                        refOn;
        logic [SW-1:0]               settleCnt;
        logic                        settled;
        logic                        refDrive;
        logic                        pinRef;
        logic [3:0]                  pos;
        logic [3:0]                  neg;
        logic                        posGnd;
        logic                        negGnd;
        logic                        start;
        logic                        ack;
        logic [31:0]                 dat;
    } adcs_regs_t;

    adcs_regs_t st_r;
    adcs_regs_t st_nxt;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    function automatic logic [3:0] pairBase(input logic [3:0] c);
        pairBase = {c[3:1], 1'b0};
    endfunction : pairBase
    function automatic logic isReserved(input logic [3:0] c);
        isReserved = (c >= CS_RSV_MIN);
    endfunction : isReserved
    function automatic logic refAlways(input logic [3:0] s);
        refAlways = s[SET_SEL2] & (s[SET_REF_PIN_SELECT_BIT] | s[SET_SEL0]);
    endfunction : refAlways

    // Live configuration, used to launch a scan
    logic [3:0] cCs;
    logic [1:0] cScan;
    logic [3:0] cBase;
    logic [3:0] cFirst;
    logic [3:0] cLast;
    // Latched configuration (reference select read live from setup), steers a running scan
    logic       rSgl;
    logic [3:0] rCs;
    logic [1:0] rScan;
    logic       rMulti;
    logic       rSel1;
    logic [3:0] curPos;
    logic [3:0] curNeg;
    logic       skipTop;
    // Bus decode
    logic       wbReq;
    logic       wrEn;
    logic       rdEn;
    logic       launch;
    logic       pop;
    logic       wr;
    logic       busy;

    assign cCs    = st_r.cfg[CFG_CS_LO +: 4];
    assign cScan  = st_r.cfg[CFG_SCAN_LO +: 2];
    assign cBase  = st_r.cfg[CFG_SGL] ? cCs : pairBase(cCs);
    assign cFirst = (cScan == SCAN_SEQ) ? CH_FIRST :
                    (cScan == SCAN_UPPER) ? UP_START : cBase;
    assign cLast  = (cScan == SCAN_UPPER && cBase < UP_START) ? UP_START : cBase;

    assign rSgl    = st_r.run[CFG_SGL];
    assign rCs     = st_r.run[CFG_CS_LO +: 4];
    assign rScan   = st_r.run[CFG_SCAN_LO +: 2];
    assign rMulti  = (rScan == SCAN_SEQ) || (rScan == SCAN_UPPER);
    assign rSel1   = st_r.setup[SET_REF_PIN_SELECT_BIT];
    assign curPos  = rSgl ? st_r.cur : {st_r.cur[3:1], rCs[0]};
    assign curNeg  = {st_r.cur[3:1], ~rCs[0]};
    assign skipTop = rSgl & rSel1 & rMulti & (st_r.cur == TOP);

    assign wbReq  = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign wrEn   = wbReq & wb_we_i & wb_sel_i[0];
    assign rdEn   = wbReq & ~wb_we_i;
    assign busy   = (st_r.state != ST_IDLE);
    assign launch = wrEn & (wb_adr_i == ADR_CTRL) & wb_dat_i[CTL_START]
                    & ~busy & ~isReserved(cCs);
    assign pop    = rdEn & (wb_adr_i == ADR_RESULT) & (st_r.fill != '0);
    assign wr     = (st_r.state == ST_WAIT) & convDone;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ack   = wbReq;
        st_nxt.start = 1'b0;
        st_nxt.dat   = '0;
        // Read data, unmapped offsets read zero
        case (wb_adr_i)
            ADR_CONFIG: st_nxt.dat[7:0] = st_r.cfg;
            ADR_SETUP:  st_nxt.dat[3:0] = st_r.setup;
            ADR_STATUS:
            begin
                st_nxt.dat[STAT_BUSY]           = busy;
                st_nxt.dat[STAT_REFON]          = st_r.refOn;
                st_nxt.dat[STAT_SETTLE]         = st_r.settled;
                st_nxt.dat[STAT_RSVERR]         = st_r.rsvErr;
                st_nxt.dat[STAT_FILL +: PW + 1] = st_r.fill;
            end
            ADR_RESULT:
            begin
                st_nxt.dat[11:0]      = st_r.mem[st_r.rdPtr];
                st_nxt.dat[RES_VALID] = (st_r.fill != '0);
            end
            default: st_nxt.dat = '0;
        endcase
        // Register writes
        if (wrEn)
        begin
            case (wb_adr_i)
                ADR_CONFIG:
                begin
                    st_nxt.cfg = wb_dat_i[7:0];
                    if (!TWELVE_CH)
                        st_nxt.cfg[CFG_CS_LO + 2 +: 2] = 2'b00;
                end
                ADR_SETUP: st_nxt.setup = wb_dat_i[3:0];
                ADR_CTRL:
                begin
                    if (wb_dat_i[CTL_NACK] && busy)
                        st_nxt.stopReq = 1'b1;
                    // Reserved codes start nothing
                    if (wb_dat_i[CTL_START] && !busy)
                        st_nxt.rsvErr = isReserved(cCs);
                end
                default: ;
            endcase
        end
        // Sequencer
        case (st_r.state)
            ST_IDLE:
                if (launch)
                begin
                    st_nxt.run     = st_r.cfg;
                    st_nxt.runExt  = st_r.setup[SET_EXTCLK];
                    st_nxt.cur     = cFirst;
                    st_nxt.last    = cLast;
                    st_nxt.reps    = '0;
                    st_nxt.cnt     = '0;
                    st_nxt.stopReq = 1'b0;
                    st_nxt.wrPtr   = '0;
                    st_nxt.rdPtr   = '0;
                    st_nxt.fill    = '0;
                    st_nxt.state   = ST_ISSUE;
                end
            // Top channel is highest, so skipping it ends the scan
            ST_ISSUE:
                if (skipTop)
                    st_nxt.state = ST_IDLE;
                else
                begin
                    st_nxt.pos    = curPos;
                    st_nxt.neg    = rSgl ? CH_FIRST : curNeg;
                    st_nxt.posGnd = rSel1 & (curPos == TOP);
                    st_nxt.negGnd = rSgl | (rSel1 & (curNeg == TOP));
                    st_nxt.start  = 1'b1;
                    st_nxt.cnt    = st_r.cnt + 5'h01;
                    st_nxt.state  = ST_WAIT;
                end
            ST_WAIT:
                if (convDone)
                begin
                    st_nxt.state = ST_ISSUE;
                    st_nxt.reps  = st_r.reps + 4'h1;
                    case (rScan)
                        SCAN_SEQ, SCAN_UPPER:
                        begin
                            if (st_r.cur >= st_r.last || st_r.stopReq)
                                st_nxt.state = ST_IDLE;
                            st_nxt.cur = st_r.cur + (rSgl ? 4'h1 : 4'h2);
                        end
                        SCAN_REP:
                            if ((!st_r.runExt && st_r.reps == REPEAT_CNT - 4'h1)
                                || st_r.stopReq)
                                st_nxt.state = ST_IDLE;
                        default:
                            if (!st_r.runExt || st_r.stopReq)
                                st_nxt.state = ST_IDLE;
                    endcase
                end
            default: st_nxt.state = ST_IDLE;
        endcase
        // Result memory, oldest first; overwrites oldest when full
        if (wr)
        begin
            st_nxt.mem[st_r.wrPtr] = {st_r.pos, convData};
            st_nxt.wrPtr = st_r.wrPtr + 1'b1;
        end
        if (pop || (wr && st_r.fill == FULL))
            st_nxt.rdPtr = st_r.rdPtr + 1'b1;
        if (wr && !pop && st_r.fill != FULL)
            st_nxt.fill = st_r.fill + 1'b1;
        else if (pop && !wr)
            st_nxt.fill = st_r.fill - 1'b1;
        // Reference: always-on settings hold until setup rewritten
        st_nxt.refOn    = refAlways(st_r.setup)
                          | (st_r.setup[SET_SEL2] & busy);
        st_nxt.refDrive = st_r.setup[SET_SEL2] & st_r.setup[SET_REF_PIN_SELECT_BIT];
        st_nxt.pinRef   = st_r.setup[SET_REF_PIN_SELECT_BIT];
        if (!st_r.refOn)
        begin
            st_nxt.settleCnt = '0;
            st_nxt.settled   = 1'b0;
        end
        else if (st_r.settleCnt != SETTLE)
            st_nxt.settleCnt = st_r.settleCnt + 1'b1;
        else
            st_nxt.settled = 1'b1;
        if (srst)
        begin
            st_nxt       = '0;
            st_nxt.cfg   = CONFIG_RST;
            st_nxt.setup = SETUP_RST;
            st_nxt.state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o    = st_r.dat;
    assign wb_ack_o    = st_r.ack;
    assign convStart   = st_r.start;
    assign muxPos      = st_r.pos;
    assign muxNeg      = st_r.neg;
    assign posGround   = st_r.posGnd;
    assign negGround   = st_r.negGnd;
    assign refPowerOn  = st_r.refOn;
    assign refPinDrive = st_r.refDrive;
    assign refPinIn    = st_r.pinRef;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    four_ch_mask_a: assert property (!TWELVE_CH |-> cCs[3:2] == 2'b00)
        else $error("upper select bits not zero");
    se_ground_a: assert property (convStart && rSgl && rSel1
        && muxPos == TOP |-> posGround && negGround)
        else $error("shared pin read not grounded");
    diff_ground_a: assert property (convStart && !rSgl && rSel1
        && muxNeg == TOP |-> negGround && !posGround)
        else $error("top pair not ground referenced");
    pair_pol_a: assert property (convStart && !rSgl |->
        muxPos[0] == rCs[0] && muxNeg == {muxPos[3:1], ~rCs[0]})
        else $error("pair polarity wrong");
    seq_first_a: assert property (launch && cScan == SCAN_SEQ
        |-> ##2 convStart && muxPos[3:1] == CH_FIRST[3:1])
        else $error("scan not from input 0");
    upper_first_a: assert property (launch && cScan == SCAN_UPPER
        |-> ##2 convStart && muxPos[3:1] == UP_START[3:1])
        else $error("upper scan start wrong");
    rep_count_a: assert property ($fell(busy) && rScan == SCAN_REP
        && !st_r.runExt && !st_r.stopReq |-> st_r.cnt == 5'h08)
        else $error("repeat count not eight");
    one_count_a: assert property ($fell(busy) && rScan == SCAN_ONE
        && !st_r.runExt |-> st_r.cnt == 5'h01)
        else $error("single conversion count wrong");
    ext_hold_a: assert property (busy && st_r.runExt && rScan[0]
        && !st_r.stopReq |=> busy)
        else $error("external repeat ended early");
    skip_pin_a: assert property (convStart && rSgl && rSel1
        && rMulti |-> muxPos != TOP)
        else $error("shared pin converted in scan");
    ref_hold_a: assert property (refAlways(st_r.setup)
        && $stable(st_r.setup) |=> refPowerOn)
        else $error("reference dropped");
    reset_cfg_a: assert property ($past(srst) |->
        st_r.cfg == CONFIG_RST && !refPinIn)
        else $error("power-up configuration wrong");

    seq_done_c: cover property ($fell(busy) && rScan == SCAN_SEQ && st_r.cnt > 5'h02);
    rep_done_c: cover property ($fell(busy) && rScan == SCAN_REP);
    ext_stop_c: cover property ($fell(busy) && st_r.runExt && st_r.stopReq);
    wrap_c:     cover property (wr && st_r.fill == FULL);

endmodule : adcs_scan_seq

// ==== sim/adcs_conv_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Converter stand-in
// ------------------------------------------------------------
// Latency is set per test; the result byte encodes the mux inputs
module adcs_conv_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Converter side
    input  wire logic       convStart,
    input  wire logic [3:0] muxPos,
    input  wire logic [3:0] muxNeg,
    input  wire logic       posGround,
    input  wire logic       negGround,
    input  wire logic [3:0] lat,
    output logic            convDone,
    output logic      [7:0] convData
);
    logic [3:0] cnt;
    logic       run;
    logic [7:0] res;
    // Byte toggles while not valid, so a stale value is never mistaken
    always_ff @(posedge clk_sys)
    begin
        convDone <= 1'b0;
        convData <= ~convData;
        if (srst)
        begin
            run      <= 1'b0;
            convData <= 8'h5a;
        end
        else if (convStart)
        begin
            run <= 1'b1;
            cnt <= lat;
            res <= {muxPos, muxNeg} ^ {posGround, 3'h0, negGround, 3'h0};
        end
        else if (run && cnt == 4'h0)
        begin
            run      <= 1'b0;
            convDone <= 1'b1;
            convData <= res;
        end
        else if (run)
            cnt <= cnt - 4'h1;
    end
endmodule : adcs_conv_model

// ==== sim/adcs_scan_seq_tb.sv ====
`timescale 1ns/1ps
module adcs_scan_seq_tb import adcs_pkg::*;;
    logic        clk_sys, srst, wbCyc, wbStb, wbWe, convStart, posGround, negGround;
    logic        convDone, wbAck, refPowerOn, refPinDrive, refPinIn;
    logic [4:0]  wbAdr;
    logic [31:0] wbDatI, wbDatO, rdData;
    logic [3:0]  muxPos, muxNeg, lat;
    logic [7:0]  convData;
    logic [9:0]  obsQ[$], expQ[$];
    int          miscompares, samples_checked, n, v;
    bit          s1;
    logic        cs4, pg4, ng4, cd4;
    logic [3:0]  mp4, mn4;
    logic [7:0]  cdat4;
    logic [31:0] datO4, rd4;
    // ------------------------------------------------------------
    // Design, converter and clock
    // ------------------------------------------------------------
    adcs_scan_seq #(.TWELVE_CH(1'b1), .RES_DEPTH(16), .REF_SETTLE_CYCLES(20)) uut (
        .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .convStart(convStart), .muxPos(muxPos),
        .muxNeg(muxNeg), .posGround(posGround), .negGround(negGround),
        .convDone(convDone), .convData(convData), .refPowerOn(refPowerOn),
        .refPinDrive(refPinDrive), .refPinIn(refPinIn));
    adcs_conv_model cnv (.clk_sys(clk_sys), .srst(srst), .convStart(convStart),
        .muxPos(muxPos), .muxNeg(muxNeg), .posGround(posGround),
        .negGround(negGround), .lat(lat), .convDone(convDone), .convData(convData));
    // Four-channel variant shares the bus; its own converter keeps it in step
    adcs_scan_seq #(.TWELVE_CH(1'b0), .RES_DEPTH(16), .REF_SETTLE_CYCLES(20)) uut4 (
        .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
        .wb_dat_o(datO4), .wb_ack_o(), .convStart(cs4), .muxPos(mp4),
        .muxNeg(mn4), .posGround(pg4), .negGround(ng4), .convDone(cd4),
        .convData(cdat4), .refPowerOn(), .refPinDrive(), .refPinIn());
    adcs_conv_model cnv4 (.clk_sys(clk_sys), .srst(srst), .convStart(cs4),
        .muxPos(mp4), .muxNeg(mn4), .posGround(pg4), .negGround(ng4),
        .lat(lat), .convDone(cd4), .convData(cdat4));
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (convStart === 1'b1)
            obsQ.push_back({posGround, negGround, muxPos, muxNeg});
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wbx(input logic we, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, a, d};
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end while (wbAck !== 1'b1 && k < 50);
        rdData = wbDatO;
        rd4 = datO4;
        {wbCyc, wbStb} <= 2'b00;
        if (k >= 50)
        begin
            chk("ack", 0, 1);
            summarize();
        end
    endtask : wbx
    task automatic waitIdle;
        int k;
        k = 0;
        do
        begin
            wbx(1'b0, ADR_STATUS, 32'h0);
            k++;
        end while (rdData[STAT_BUSY] !== 1'b0 && k < 300);
        if (k >= 300)
        begin
            chk("idle", 0, 1);
            summarize();
        end
    endtask : waitIdle
    // Entry is {posGround, negGround, muxPos, muxNeg}
    function automatic logic [9:0] ent(bit sgl, logic [3:0] c, bit g);
        if (sgl)
            return {g && c == 4'hb, 1'b1, c, 4'h0};
        return {g && c == 4'hb, g && (c ^ 4'h1) == 4'hb, c, c ^ 4'h1};
    endfunction : ent
    task automatic run(input bit sgl, input logic [3:0] cs, input logic [1:0] sc);
        int i, lo, hi;
        expQ.delete();
        if (sc == SCAN_REP)
            repeat (8) expQ.push_back(ent(sgl, cs, s1));
        else if (sc == SCAN_ONE)
            expQ.push_back(ent(sgl, cs, s1));
        else
        begin
            lo = (sc == SCAN_UPPER) ? 6 : 0;
            hi = (cs > lo) ? cs : lo;
            // Shared pin used as reference drops out of single-ended scans
            if (sgl && s1 && hi == 11)
                hi = 10;
            for (i = lo; i <= hi; i += sgl ? 1 : 2)
                expQ.push_back(ent(sgl, sgl ? i[3:0] : i[3:0] | {3'h0, cs[0]}, s1));
        end
        wbx(1'b1, ADR_CONFIG, {25'h0, sc, cs, sgl});
        obsQ.delete();
        lat <= 4'($urandom % 8);
        wbx(1'b1, ADR_CTRL, 32'h1);
        waitIdle();
        chk("count", obsQ.size(), expQ.size());
        for (i = 0; i < expQ.size() && i < obsQ.size(); i++)
            chk("mux", obsQ[i], expQ[i]);
        foreach (expQ[i])
        begin
            wbx(1'b0, ADR_RESULT, 32'h0);
            v = {expQ[i][7:0] ^ {expQ[i][9], 3'h0, expQ[i][8], 3'h0}};
            chk("result", {rdData[12], rdData[7:0]}, {1'b1, v[7:0]});
        end
        wbx(1'b0, ADR_RESULT, 32'h0);
        chk("empty", rdData[RES_VALID], 0);
        $display("test done sgl %0d cs %0d scan %0d", sgl, cs, sc);
    endtask : run
    task automatic ext(input logic [1:0] sc);
        wbx(1'b1, ADR_CONFIG, {25'h0, sc, 4'h5, 1'b1});
        obsQ.delete();
        wbx(1'b1, ADR_CTRL, 32'h1);
        for (n = 0; n < 500 && obsQ.size() < 3; n++)
            @(posedge clk_sys);
        if (obsQ.size() < 3)
        begin
            chk("extrun", 0, 1);
            summarize();
        end
        wbx(1'b1, ADR_CTRL, 32'h2);
        waitIdle();
        chk("ext", obsQ.size() >= 3 && obsQ.size() <= 5, 1);
        foreach (obsQ[i])
            chk("extmux", obsQ[i], ent(1'b1, 4'h5, 1'b0));
        $display("test done external scan %0d", sc);
    endtask : ext
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        {clk_sys, srst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, lat} = {3'b010, 43'h0};
        v = $urandom(81);
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        wbx(1'b0, ADR_CONFIG, 32'h0);
        chk("config", rdData, 32'h1);
        wbx(1'b0, ADR_SETUP, 32'h0);
        chk("setup", rdData, 32'h0);
        wbx(1'b1, 5'h14, 32'hffffffff);
        wbx(1'b0, 5'h14, 32'h0);
        chk("unmapped", rdData, 32'h0);
        wbx(1'b1, ADR_CONFIG, 32'h1f);
        wbx(1'b0, ADR_CONFIG, 32'h0);
        chk("cfg4", rd4, 32'h07);
        chk("cfg12", rdData, 32'h1f);
        wbx(1'b1, ADR_SETUP, 32'h7);
        s1 = 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("refpins", {refPowerOn, refPinDrive, refPinIn}, 3'b111);
        // Host waits for the settled flag before trusting results
        for (n = 0; n < 40 && rdData[STAT_SETTLE] !== 1'b1; n++)
            wbx(1'b0, ADR_STATUS, 32'h0);
        chk("settled", rdData[STAT_SETTLE], 1);
        if (rdData[STAT_SETTLE] !== 1'b1)
            summarize();
        wbx(1'b1, ADR_SETUP, 32'h7);
        repeat (3) @(posedge clk_sys);
        chk("refstay", refPowerOn, 1);
        run(1'b1, 4'hb, SCAN_SEQ);
        run(1'b0, 4'hb, SCAN_SEQ);
        run(1'b0, 4'ha, SCAN_SEQ);
        run(1'b1, 4'hb, SCAN_ONE);
        run(1'b1, 4'h3, SCAN_UPPER);
        repeat (14)
        begin
            v = $urandom % 8;
            wbx(1'b1, ADR_SETUP, v);
            s1 = v[1];
            v = $urandom;
            run((v[1:0] == SCAN_UPPER) | v[2], 4'(v[7:4] % 12), v[1:0]);
        end
        wbx(1'b1, ADR_CONFIG, {25'h0, SCAN_ONE, 4'hc, 1'b1});
        obsQ.delete();
        wbx(1'b1, ADR_CTRL, 32'h1);
        repeat (20) @(posedge clk_sys);
        wbx(1'b0, ADR_STATUS, 32'h0);
        chk("reserved", {rdData[STAT_RSVERR], obsQ.size() == 0}, 2'b11);
        wbx(1'b1, ADR_SETUP, 32'h8);
        s1 = 1'b0;
        ext(SCAN_REP);
        ext(SCAN_ONE);
        wbx(1'b1, ADR_SETUP, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk("refoff", {refPowerOn, refPinIn}, 2'b00);
        summarize();
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
endmodule : adcs_scan_seq_tb
